/* File: verilog/ppm_params.svh */
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_MODE_OFF 12'h000
`define PPM_CTRL_OFF 12'h004
`define PPM_ADDR_OFF 12'h008
`define PPM_DOUT_OFF 12'h00C
`define PPM_DIN_OFF 12'h010
`define PPM_STAT_OFF 12'h014
`define PPM_MASK_OFF 12'h018
`define PPM_BUSY_BIT 15
`define PPM_INTERRUPT_REQUEST_MODE_LSB 13
`define PPM_ADDRESS_STEP_MODE_LSB 11
`define PPM_MODE_LSB 8
`define PPM_SETUP_WAIT_FIELD_LSB 6
`define PPM_STROBE_WAIT_FIELD_LSB 2
`define PPM_END_WAIT_FIELD_LSB 0
`define PPM_MODE_WMASK 32'h00007BFF
`define PPM_CTRL_EN_BIT 15
`define PPM_CTRL_CSF_LSB 6
`define PPM_CTRL_WMASK 32'h000080C0
`define PPM_CTRL_GO_BIT 0
`define PPM_CTRL_DIR_BIT 1
`define PPM_CSF_CHIPSEL 2'h2
`endif

/* File: verilog/ppm_pkg.sv */
package ppm_pkg;
	typedef enum logic [4:0] {
		PPM_IDLE = 5'h01,
		PPM_ADDR = 5'h02,
		PPM_SETUP = 5'h04,
		PPM_STROBE = 5'h08,
		PPM_HOLD = 5'h10
	} ppm_state_t;
	typedef enum logic [1:0] {
		PPM_PM_LEGACY = 2'h0,
		PPM_PM_ENH = 2'h1,
		PPM_PM_MASTER2 = 2'h2,
		PPM_PM_MASTER1 = 2'h3
	} ppm_port_mode_t;
	typedef enum logic [1:0] {
		PPM_IRQ_NONE = 2'h0,
		PPM_IRQ_CYCLE = 2'h1,
		PPM_IRQ_BUF3 = 2'h2,
		PPM_IRQ_RSVD = 2'h3
	} ppm_irq_mode_t;
	typedef enum logic [1:0] {
		PPM_INC_NONE = 2'h0,
		PPM_INC_UP = 2'h1,
		PPM_INC_DOWN = 2'h2,
		PPM_INC_BUF = 2'h3
	} ppm_inc_mode_t;
endpackage

/* File: verilog/ppm_core.sv */
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_core
	import ppm_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	output logic [ADDR_W-1:0] port_address_lines_out,
	output logic [ADDR_W-1:0] port_address_lines_oe_out,
	input wire logic [1:0] port_address_lines_in,
	output logic [7:0] port_data_bus_out,
	output logic port_data_bus_oe_out,
	input wire logic [7:0] port_data_bus_in,
	output logic read_strobe_out,
	output logic read_strobe_oe_out,
	input wire logic read_strobe_in,
	output logic write_strobe_out,
	output logic write_strobe_oe_out,
	input wire logic write_strobe_in,
	output logic enable_strobe_out,
	output logic chip_select_out,
	output logic chip_select_oe_out,
	input wire logic chip_select_in
);
	initial begin
		if (ADDR_W != 16) $error("ppm_core: ADDR_W must be 16");
	end

	ppm_state_t state_reg, state_next;
	logic [14:0] mode_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] addr_reg;
	logic [7:0] dout_reg;
	logic [7:0] din_reg;
	logic [1:0] stat_reg;
	logic [1:0] mask_reg;
	logic [3:0] cnt_reg;
	logic dir_rd_reg;
	logic [7:0] rbuf_reg [4];
	logic [7:0] wbuf_reg [4];
	logic [1:0] rptr_reg;
	logic [1:0] wptr_reg;
	logic [7:0] data_out_reg;
	logic [4:0] sync1_reg, sync2_reg, prev_reg;

	// Field extraction
	wire [1:0] interrupt_request_mode = mode_reg[`PPM_INTERRUPT_REQUEST_MODE_LSB +: 2];
	wire [1:0] address_step_mode = mode_reg[`PPM_ADDRESS_STEP_MODE_LSB +: 2];
	wire [1:0] pmode = mode_reg[`PPM_MODE_LSB +: 2];
	wire [1:0] setup_wait_field = mode_reg[`PPM_SETUP_WAIT_FIELD_LSB +: 2];
	wire [3:0] strobe_wait_field = mode_reg[`PPM_STROBE_WAIT_FIELD_LSB +: 4];
	wire [1:0] end_wait_field = mode_reg[`PPM_END_WAIT_FIELD_LSB +: 2];
	wire port_en = ctrl_reg[`PPM_CTRL_EN_BIT];
	wire cs_is_sel = ctrl_reg[`PPM_CTRL_CSF_LSB +: 2] == `PPM_CSF_CHIPSEL;
	wire is_master = pmode[1];
	wire busy = state_reg != PPM_IDLE;

	// APB decode; answers in the access cycle, no waits
	wire apb_wr = psel_in && penable_in && pwrite_in;
	wire apb_rd = psel_in && penable_in && !pwrite_in;
	wire hit_mode = paddr_in == `PPM_MODE_OFF;
	wire hit_ctrl = paddr_in == `PPM_CTRL_OFF;
	wire hit_addr = paddr_in == `PPM_ADDR_OFF;
	wire hit_dout = paddr_in == `PPM_DOUT_OFF;
	wire hit_din = paddr_in == `PPM_DIN_OFF;
	wire hit_stat = paddr_in == `PPM_STAT_OFF;
	wire hit_mask = paddr_in == `PPM_MASK_OFF;
	wire hit_any = hit_mode | hit_ctrl | hit_addr | hit_dout | hit_din | hit_stat | hit_mask;
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !hit_any;
	wire go = apb_wr && hit_ctrl && pwdata_in[`PPM_CTRL_GO_BIT];
	// Enable taken from the same write, so one write can enable and start
	wire start = go && pwdata_in[`PPM_CTRL_EN_BIT] && is_master && !busy;
	// Write masks applied at full width, then cut to the stored bits
	wire [31:0] mode_wdata = pwdata_in & `PPM_MODE_WMASK;
	wire [31:0] ctrl_wdata = pwdata_in & `PPM_CTRL_WMASK;

	// Timing: field value plus one, strobe-zero overrides
	wire wm_zero = strobe_wait_field == 4'h0;
	wire [3:0] setup_len = wm_zero ? 4'h0 : {2'b00, setup_wait_field};
	wire [3:0] strobe_len = strobe_wait_field;
	// Read with zero strobe field ends at the strobe, no hold
	wire skip_hold = wm_zero && dir_rd_reg;
	wire [3:0] hold_len = wm_zero ? 4'h0 : {2'b00, end_wait_field};
	wire cnt_done = cnt_reg == 4'h0;

	// Master sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PPM_IDLE: if (start) state_next = PPM_ADDR;
			PPM_ADDR: if (cnt_done) state_next = PPM_SETUP;
			PPM_SETUP: if (cnt_done) state_next = PPM_STROBE;
			PPM_STROBE: if (cnt_done) state_next = skip_hold ? PPM_IDLE : PPM_HOLD;
			PPM_HOLD: if (cnt_done) state_next = PPM_IDLE;
			default: state_next = PPM_IDLE;
		endcase
	end
	wire cycle_end = (state_reg == PPM_STROBE && cnt_done && skip_hold) ||
		(state_reg == PPM_HOLD && cnt_done);

	// Address stepping; bit 14 skipped when chip select follows busy
	// Bits 10:2 and 14 form one counter, carry skips 13:11
	wire [9:0] step_in = {addr_reg[14], addr_reg[10:2]};
	wire [9:0] step_up = step_in + 10'h001;
	wire [9:0] step_dn = step_in - 10'h001;
	wire [9:0] step_sel = (address_step_mode == PPM_INC_UP) ? step_up :
		(address_step_mode == PPM_INC_DOWN) ? step_dn : step_in;
	wire step_en = address_step_mode == PPM_INC_UP || address_step_mode == PPM_INC_DOWN;
	wire [15:0] addr_stepped = {addr_reg[15], cs_is_sel ? addr_reg[14] : step_sel[9],
		addr_reg[13:11], step_sel[8:0], addr_reg[1:0]};

	// Slave pin synchronisers: cs, rd, wr, a1, a0
	// Host pins cross two flops; a third stage gives the edge
	wire [4:0] pins_raw = {chip_select_in, read_strobe_in, write_strobe_in, port_address_lines_in};
	wire slave_on = port_en && !is_master;
	wire s_cs = sync2_reg[4];
	wire s_rd_rise = s_cs && sync2_reg[3] && !prev_reg[3];
	wire s_wr_fall = s_cs && !sync2_reg[2] && prev_reg[2];
	// Legacy slave ignores address pins; enhanced uses two address inputs
	wire [1:0] s_idx = (pmode == PPM_PM_ENH) ? sync2_reg[1:0] :
		(address_step_mode == PPM_INC_BUF ? 2'h0 : 2'h0);
	wire buf_step = pmode == PPM_PM_LEGACY && address_step_mode == PPM_INC_BUF;
	wire [1:0] wr_idx = buf_step ? wptr_reg : s_idx;
	wire [1:0] rd_idx = buf_step ? rptr_reg : s_idx;
	wire s_wr_ev = slave_on && s_wr_fall;
	wire s_rd_ev = slave_on && s_rd_rise;
	wire buf3_hit = (s_wr_ev && wr_idx == 2'h3) || (s_rd_ev && rd_idx == 2'h3);

	// Interrupt events, mode 00 and 11 give nothing
	wire ev_cycle = (interrupt_request_mode == PPM_IRQ_CYCLE) && (cycle_end || s_wr_ev || s_rd_ev);
	wire ev_buf = (interrupt_request_mode == PPM_IRQ_BUF3) && buf3_hit;
	wire [1:0] ev_vec = {ev_buf, ev_cycle};
	wire rd_stat = apb_rd && hit_stat;

	// Counter loads on entry to a phase and counts down to zero
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_reg <= PPM_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			case (state_next)
				PPM_ADDR: cnt_reg <= (state_reg == PPM_ADDR) ? cnt_reg - 4'h1 : setup_len;
				PPM_SETUP: cnt_reg <= (state_reg == PPM_SETUP) ? cnt_reg - 4'h1 : setup_len;
				PPM_STROBE: cnt_reg <= (state_reg == PPM_STROBE) ? cnt_reg - 4'h1 : strobe_len;
				PPM_HOLD: cnt_reg <= (state_reg == PPM_HOLD) ? cnt_reg - 4'h1 : hold_len;
				default: cnt_reg <= 4'h0;
			endcase
		end
	end

	// Registers kept in small blocks, one per register
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mode_reg <= 15'h0000;
		end else if (apb_wr && hit_mode) begin
			mode_reg <= mode_wdata[14:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ctrl_reg <= 16'h0000;
		end else if (apb_wr && hit_ctrl) begin
			ctrl_reg <= ctrl_wdata[15:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mask_reg <= 2'h0;
		end else if (apb_wr && hit_mask) begin
			mask_reg <= pwdata_in[1:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			dout_reg <= 8'h00;
		end else if (apb_wr && hit_dout) begin
			dout_reg <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			dir_rd_reg <= 1'b0;
		end else if (start) begin
			dir_rd_reg <= pwdata_in[`PPM_CTRL_DIR_BIT];
		end
	end

	// Address register: software write, then stepped after each cycle in up or down step mode
	// Write while busy is dropped so the running frame keeps its address
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			addr_reg <= 16'h0000;
		end else if (apb_wr && hit_addr && !busy) begin
			addr_reg <= pwdata_in[15:0];
		end else if (cycle_end && step_en) begin
			addr_reg <= addr_stepped;
		end
	end

	// Status: event set wins over read clear
	// A read in the same cycle as an event keeps the event
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			stat_reg <= 2'h0;
		end else begin
			stat_reg <= (rd_stat ? 2'h0 : stat_reg) | ev_vec;
		end
	end
	assign irq_out = |(stat_reg & mask_reg);

	// Read data captured at end of a master read strobe
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			din_reg <= 8'h00;
		end else if (state_reg == PPM_STROBE && cnt_done && dir_rd_reg) begin
			din_reg <= port_data_bus_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			prev_reg <= 5'h00;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// Slave buffers, four entries each
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_buf
			always_ff @(posedge clock_in) begin
				if (sys_rst_in) begin
					wbuf_reg[gi] <= 8'h00;
					rbuf_reg[gi] <= 8'h00;
				end else begin
					if (s_wr_ev && wr_idx == gi) wbuf_reg[gi] <= port_data_bus_in;
					if (apb_wr && hit_din && rd_idx == gi) rbuf_reg[gi] <= pwdata_in[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			wptr_reg <= 2'h0;
			rptr_reg <= 2'h0;
		end else if (buf_step) begin
			if (s_wr_ev) wptr_reg <= wptr_reg + 2'h1;
			if (s_rd_ev) rptr_reg <= rptr_reg + 2'h1;
		end
	end

	// Pin drive
	// In a write the bus is released only after the hold phase, so data outlives the strobe
	wire in_addr = state_reg == PPM_ADDR;
	wire in_strobe = state_reg == PPM_STROBE;
	wire m_wr_drive = busy && !dir_rd_reg && !in_addr;
	wire s_drive = slave_on && s_cs && sync2_reg[3];
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			data_out_reg <= 8'h00;
		end else begin
			data_out_reg <= (state_next == PPM_ADDR) ? addr_reg[7:0] :
				is_master ? dout_reg : rbuf_reg[rd_idx];
		end
	end
	assign port_data_bus_out = data_out_reg;
	assign port_data_bus_oe_out = (is_master && (m_wr_drive || in_addr)) || s_drive;
	assign port_address_lines_out = cs_is_sel ? {1'b0, 1'b0, addr_reg[13:0]} : {1'b0, addr_reg[14:0]};
	assign port_address_lines_oe_out = (port_en && is_master) ? 16'h7FFF : 16'h0000;
	// Mode 11: direction plus enable; mode 10: separate strobes
	wire m1 = pmode == PPM_PM_MASTER1;
	// Strobes idle low, except the mode 11 direction after a read, and a disabled port starts no access
	assign read_strobe_out = m1 ? port_en && dir_rd_reg : in_strobe && dir_rd_reg;
	assign write_strobe_out = m1 ? 1'b0 : in_strobe && !dir_rd_reg;
	assign enable_strobe_out = m1 && in_strobe;
	assign read_strobe_oe_out = port_en && is_master;
	assign write_strobe_oe_out = port_en && is_master && !m1;
	assign chip_select_out = cs_is_sel ? busy : addr_reg[14];
	assign chip_select_oe_out = port_en && is_master;

	// Register read mux
	wire [31:0] mode_rd = {16'h0000, busy, mode_reg};
	wire [31:0] ctrl_rd = {16'h0000, ctrl_reg};
	wire [31:0] addr_rd = {16'h0000, addr_reg};
	wire [31:0] dout_rd = {24'h000000, dout_reg};
	wire [31:0] din_rd = {24'h000000, is_master ? din_reg : wbuf_reg[wr_idx]};
	wire [31:0] stat_rd = {30'h0, stat_reg};
	wire [31:0] mask_rd = {30'h0, mask_reg};
	always_comb begin
		prdata_out = 32'h00000000;
		if (hit_mode) prdata_out = mode_rd;
		else if (hit_ctrl) prdata_out = ctrl_rd;
		else if (hit_addr) prdata_out = addr_rd;
		else if (hit_dout) prdata_out = dout_rd;
		else if (hit_din) prdata_out = din_rd;
		else if (hit_stat) prdata_out = stat_rd;
		else if (hit_mask) prdata_out = mask_rd;
	end
endmodule

/* File: bench/ppm_monitor.sv */
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_monitor (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	input wire logic irq_out,
	input wire logic port_data_bus_oe_out,
	input wire logic read_strobe_out,
	input wire logic write_strobe_out,
	input wire logic enable_strobe_out,
	input wire logic chip_select_out
);
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);
	logic [31:0] mode_reg;
	logic [31:0] ctrl_reg;
	logic [1:0] mask_reg;
	logic [5:0] oe_cnt_reg;
	logic saw_wr_reg;
	wire acc = psel_in && penable_in;
	wire wr = acc && pwrite_in;
	wire [1:0] pmode = mode_reg[9:8];
	// Write frames only: a read frame drops the bus after its address phase
	wire [5:0] frame_len = (mode_reg[5:2] == 4'h0) ? 6'h04 : 6'h04 + {mode_reg[7:6], 1'b0} + mode_reg[5:2] + mode_reg[1:0];
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mode_reg <= '0;
			ctrl_reg <= '0;
			mask_reg <= '0;
			oe_cnt_reg <= '0;
			saw_wr_reg <= 1'b0;
		end else begin
			if (wr && paddr_in == `PPM_MODE_OFF) mode_reg <= pwdata_in & `PPM_MODE_WMASK;
			if (wr && paddr_in == `PPM_CTRL_OFF) ctrl_reg <= pwdata_in & `PPM_CTRL_WMASK;
			if (wr && paddr_in == `PPM_MASK_OFF) mask_reg <= pwdata_in[1:0];
			oe_cnt_reg <= port_data_bus_oe_out ? oe_cnt_reg + 6'h01 : 6'h00;
			saw_wr_reg <= port_data_bus_oe_out && (saw_wr_reg || write_strobe_out);
		end
	end
	a_no_access_off: assert property (
		!ctrl_reg[15] |-> !(read_strobe_out || write_strobe_out || enable_strobe_out))
		else $error("strobe while disabled");
	a_busy_strobe: assert property (
		write_strobe_out && acc && !pwrite_in && paddr_in == `PPM_MODE_OFF |-> prdata_out[15])
		else $error("busy low during strobe");
	a_cycle_irq: assert property (
		$fell(write_strobe_out) && mode_reg[14:13] == 2'h1 && mask_reg[0] |-> ##[1:8] irq_out)
		else $error("no cycle interrupt");
	a_mask_quiet: assert property (mask_reg == 2'h0 |-> !irq_out)
		else $error("masked interrupt seen");
	a_bad_addr: assert property (acc && paddr_in > `PPM_MASK_OFF |-> pslverr_out)
		else $error("unmapped access not refused");
	a_cs_select: assert property (
		ctrl_reg[7:6] == `PPM_CSF_CHIPSEL && write_strobe_out |-> chip_select_out)
		else $error("chip select low in strobe");
	a_split_strobes: assert property (
		pmode == 2'h2 |-> !enable_strobe_out && !(read_strobe_out && write_strobe_out))
		else $error("strobe mix in mode 10");
	a_frame_len: assert property (
		$fell(port_data_bus_oe_out) && saw_wr_reg && pmode == 2'h2 |-> oe_cnt_reg == frame_len)
		else $error("write frame length wrong");
endmodule
bind ppm_core ppm_monitor u_mon (.clock_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
	.pwdata_in, .prdata_out, .pslverr_out, .irq_out, .port_data_bus_oe_out, .read_strobe_out,
	.write_strobe_out, .enable_strobe_out, .chip_select_out);

/* File: bench/ppm_far_side.sv */
`timescale 1ns/1ps
module ppm_far_side (
	input wire logic clock_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] data_in,
	input wire logic rd_in,
	input wire logic wr_in,
	output logic [7:0] data_out,
	output logic [1:0] host_addr_out = 2'h0,
	output logic host_wr_out = 1'b0,
	output logic host_cs_out = 1'b0
);
	logic [7:0] mem [256];
	logic [7:0] last_q = 8'h00;
	logic [7:0] host_dat = 8'h00;
	// Released bus toggles so a stale byte never passes for data
	assign data_out = host_cs_out ? host_dat : (rd_in ? mem[addr_in[7:0]] : ~last_q);
	always @(posedge clock_in) begin
		last_q <= data_out;
		if (wr_in) mem[addr_in[7:0]] <= data_in;
	end
	task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_in);
		host_addr_out <= a;
		host_dat <= d;
		host_cs_out <= 1'b1;
		host_wr_out <= 1'b1;
		repeat (4) @(posedge clock_in);
		host_wr_out <= 1'b0;
		repeat (4) @(posedge clock_in);
		host_cs_out <= 1'b0;
	endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "ppm_params.svh"
module testbench;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pw = 32'h0, prd;
	wire [31:0] prdata;
	wire [15:0] pao;
	wire [7:0] dbo, dbi;
	wire [1:0] hadr;
	wire pready, irq, rso, wso, hwr, hcs;
	int num_errors = 0, check_count = 0;
	// Reserved interrupt mode never programmed
	logic [15:0] t_mode [6] = '{16'h2AFF, 16'h1200, 16'h2249, 16'h2A04, 16'h2A04, 16'h2A04};
	logic [15:0] t_ctl [6] = '{16'h8001, 16'h8001, 16'h8001, 16'h8001, 16'h8081, 16'h0001};
	logic [15:0] t_a0 [6] = '{16'h0010, 16'h0018, 16'h0020, 16'h07FC, 16'h07FC, 16'h0030};
	logic [15:0] t_a1 [6] = '{16'h0014, 16'h0014, 16'h0020, 16'h4000, 16'h0000, 16'h0030};
	logic [1:0] t_st [6] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h0};
	logic [1:0] t_mk [6] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3};
	logic [31:0] sm [2] = '{32'h00005800, 32'h00004100};
	initial forever #20 clk = ~clk;
	ppm_core dut (.clock_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pw), .prdata_out(prdata), .pready_out(pready), .pslverr_out(), .irq_out(irq),
		.port_address_lines_out(pao), .port_address_lines_oe_out(), .port_address_lines_in(hadr),
		.port_data_bus_out(dbo), .port_data_bus_oe_out(), .port_data_bus_in(dbi), .read_strobe_out(rso),
		.read_strobe_oe_out(), .read_strobe_in(1'b0), .write_strobe_out(wso), .write_strobe_oe_out(),
		.write_strobe_in(hwr), .enable_strobe_out(), .chip_select_out(), .chip_select_oe_out(), .chip_select_in(hcs));
	ppm_far_side far (.clock_in(clk), .addr_in(pao), .data_in(dbo), .rd_in(rso), .wr_in(wso), .data_out(dbi),
		.host_addr_out(hadr), .host_wr_out(hwr), .host_cs_out(hcs));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pw <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		prd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(prd, exp);
	endtask
	task automatic go(input logic [31:0] c);
		logic seen;
		seen = 1'b0;
		apb(1'b1, `PPM_CTRL_OFF, c);
		do begin
			apb(1'b0, `PPM_MODE_OFF, 32'h0);
			seen |= prd[15];
		end while (prd[15] === 1'b1);
		chk({31'h0, seen}, {31'h0, c[15]});
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`PPM_MODE_OFF, 32'h0);
		apb(1'b1, `PPM_MODE_OFF, 32'hFFFFDFFF);
		rd(`PPM_MODE_OFF, 32'h00005BFF);
		rd(12'h01C, 32'h0);
		$display("registers done");
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `PPM_ADDR_OFF, {16'h0, t_a0[i]});
			apb(1'b1, `PPM_MODE_OFF, {16'h0, t_mode[i]});
			apb(1'b1, `PPM_MASK_OFF, {30'h0, t_mk[i]});
			apb(1'b1, `PPM_DOUT_OFF, 32'h000000A0 + 32'(i));
			go({16'h0, t_ctl[i]});
			rd(`PPM_ADDR_OFF, {16'h0, t_a1[i]});
			chk({31'h0, irq}, {31'h0, |(t_st[i] & t_mk[i])});
			rd(`PPM_STAT_OFF, {30'h0, t_st[i]});
			chk({31'h0, irq}, 32'h0);
			if (t_ctl[i][15]) chk({24'h0, far.mem[t_a0[i][7:0]]}, 32'h000000A0 + 32'(i));
			$display("master test %0d done", i);
		end
		apb(1'b1, `PPM_ADDR_OFF, 32'h00000010);
		apb(1'b1, `PPM_MODE_OFF, 32'h00002300);
		go(32'h00008003);
		rd(`PPM_DIN_OFF, 32'h000000A0);
		rd(`PPM_STAT_OFF, 32'h00000001);
		$display("mode 11 read done");
		apb(1'b1, `PPM_CTRL_OFF, 32'h00008000);
		foreach (sm[j]) begin
			apb(1'b1, `PPM_MODE_OFF, sm[j]);
			for (int i = 0; i < 4; i++) begin
				far.host_wr(2'(i), 8'h50);
				rd(`PPM_STAT_OFF, {30'h0, i == 3, 1'b0});
			end
			$display("slave test %0d done", j);
		end
		give_verdict();
	end
endmodule
